// file: hw/asir_regs.v
// Operation
// (R1) with no valid recovered data, output stream carries the idle symbol
// (R2) after reset the idle symbol is the k28.5 comma character
// (R3) idle symbol low eight bits at 0x0d, two msbs at 0x0e bits 1:0
// (R4) loop-through status bit resets to the sampled loop-through pin; here reset loads 0 and the pin is taken on the first clock after release
// (R5) read-only two-bit mode field; 00, 01, 10 mean standard video
// (R6) upper idle register keeps only bits 1:0, others read zero
`timescale 1ns/10ps
`include "asir_defines.vh"
module asir_regs #(
	parameter SYM_W = 10,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_sys,    // system clock, 125 MHz
	input  wire             sys_rst,    // async reset, active high
	input  wire [7:0]       cfg_addr,   // register offset
	input  wire [7:0]       cfg_wdata,  // write data
	input  wire             cfg_wr,     // write strobe, one cycle
	input  wire             cfg_rd,     // read strobe, one cycle
	output reg  [7:0]       cfg_rdata_q,// read data, next cycle
	output reg              cfg_rvld_q, // read data valid pulse
	input  wire             loop_pin,   // loop-through enable pin level
	input  wire [1:0]       mode_in,    // device operating state
	input  wire [SYM_W-1:0] rx_data,    // recovered character
	input  wire             rx_valid,   // recovered character is valid
	input  wire             rx_tick,    // one character slot elapsed
	output wire             rx_ready,   // fifo space, stalls recovery
	output reg  [SYM_W-1:0] out_data_q, // outgoing character
	output reg              out_vld_q,  // outgoing character strobe
	output reg              loop_en_q,  // loop-through enable status
	output reg              idle_ins_q  // current slot filled with idle
);
	reg  [7:0]       idle_lo_q;
	reg  [1:0]       idle_hi_q;
	reg  [1:0]       mode_q;
	reg              strap_q;
	reg  [7:0]       rdata_d;
	wire [SYM_W-1:0] f_data;
	wire             f_valid;
	wire [SYM_W-1:0] idle_sym;

	////////////////////////////////////////////////////////////////
	// buffering between recovery and the output slot timing
	asir_fifo #(
		.WIDTH (SYM_W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_fifo (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.in_data   (rx_data),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (rx_tick)
	);

	assign idle_sym = {idle_hi_q, idle_lo_q}; // [R3]

	////////////////////////////////////////////////////////////////
	// configuration writes; reset value is the comma character
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			idle_lo_q <= `ASIR_IDLE_RST_LO; // [R2]
			idle_hi_q <= `ASIR_IDLE_RST_HI; // [R2]
		end else if (cfg_wr) begin
			if (cfg_addr == `ASIR_OFS_IDLE_LOW)
				idle_lo_q <= cfg_wdata; // [R3]
			if (cfg_addr == `ASIR_OFS_IDLE_HIGH)
				idle_hi_q <= cfg_wdata[1:0]; // [R6]
		end
	end

	////////////////////////////////////////////////////////////////
	// strap: pin caught on the first clock after reset release, since an
	// async reset may only load constants
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			strap_q   <= 1'b0;
			loop_en_q <= 1'b0;
			mode_q    <= `ASIR_MODE_VIDEO;
		end else begin
			mode_q <= mode_in; // [R5]
			if (!strap_q) begin
				strap_q   <= 1'b1;
				loop_en_q <= loop_pin; // [R4]
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets read zero
	always @* begin
		rdata_d = 8'h00;
		case (cfg_addr)
		`ASIR_OFS_IDLE_LOW: begin
			rdata_d = idle_lo_q;
		end
		`ASIR_OFS_IDLE_HIGH: begin
			rdata_d = {6'h00, idle_hi_q}; // [R6]
		end
		`ASIR_OFS_STATUS: begin
			rdata_d[`ASIR_ST_MODE_HI:`ASIR_ST_MODE_LO] = mode_q; // [R5]
			rdata_d[`ASIR_ST_LOOP_BIT] = loop_en_q; // [R4]
		end
		default: begin
			rdata_d = 8'h00;
		end
		endcase
	end

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_rdata_q <= 8'h00;
			cfg_rvld_q  <= 1'b0;
		end else begin
			cfg_rvld_q <= cfg_rd;
			if (cfg_rd)
				cfg_rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// every slot emits one character: data if the fifo output register holds one, else idle
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			out_data_q <= {SYM_W{1'b0}};
			out_vld_q  <= 1'b0;
			idle_ins_q <= 1'b0;
		end else begin
			out_vld_q <= rx_tick;
			if (rx_tick) begin
				out_data_q <= f_valid ? f_data : idle_sym; // [R1]
				idle_ins_q <= !f_valid; // [R1]
			end
		end
	end
endmodule

// file: hw/asir_defines.vh
`ifndef ASIR_DEFINES_VH
`define ASIR_DEFINES_VH
// register offsets on the configuration port
`define ASIR_OFS_IDLE_LOW   8'h0d
`define ASIR_OFS_IDLE_HIGH  8'h0e
`define ASIR_OFS_STATUS     8'h0f
// status register field positions
`define ASIR_ST_LOOP_BIT    5
`define ASIR_ST_MODE_HI     7
`define ASIR_ST_MODE_LO     6
// idle symbol is a 10-bit character, k28.5 running-disparity-negative form
`define ASIR_SYM_W          10
`define ASIR_IDLE_RESET     10'h0fa
`define ASIR_IDLE_HI_MASK   8'h03
// reset halves of the idle symbol, split to fit the two registers
`define ASIR_IDLE_RST_LO    8'hfa
`define ASIR_IDLE_RST_HI    2'h0
// mode encodings
`define ASIR_MODE_VIDEO     2'h0
`define ASIR_FIFO_DEPTH     16
`endif

// file: hw/asir_fifo.v
`timescale 1ns/10ps
module asir_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_sys,  // system clock
	input  wire             sys_rst,  // async reset, active high
	input  wire [WIDTH-1:0] in_data,  // write data
	input  wire             in_valid, // write request
	output wire             in_ready, // space available
	output reg  [WIDTH-1:0] out_data, // registered read data
	output reg              out_valid,// read data valid
	input  wire             out_ready // consumer takes data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full;
	wire            empty;
	wire            pop;
	wire            push;

	////////////////////////////////////////////////////////////////
	// flags from pointer difference, extra msb tells full from empty
	assign full     = (wr_q[AW] != rd_q[AW]) &&
	                  (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty    = (wr_q == rd_q);
	assign in_ready = !full;
	assign push     = in_valid && !full;
	// refill the output register whenever it is empty or being drained
	assign pop      = !empty && (!out_valid || out_ready);

	always @(posedge clk_sys) begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wr_q      <= {(AW+1){1'b0}};
			rd_q      <= {(AW+1){1'b0}};
			out_data  <= {WIDTH{1'b0}};
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop) begin
				rd_q      <= rd_q + 1'b1;
				out_data  <= mem[rd_q[AW-1:0]];
				out_valid <= 1'b1;
			end else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule

// file: tb/asir_regs_props.sv
`timescale 1ns/10ps
module asir_regs_props (
	input wire       clk_sys,     // clock
	input wire       sys_rst,     // reset
	input wire [7:0] cfg_addr,    // offset
	input wire       cfg_rd,      // read
	input wire [7:0] cfg_rdata_q, // rdata
	input wire       cfg_rvld_q,  // rvalid
	input wire [1:0] mode_in,     // state
	input wire       rx_tick,     // slot
	input wire       out_vld_q,   // out strobe
	input wire       loop_en_q    // loop
);
	// one clock domain; reset masks all checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	chk_read_answer: assert property (cfg_rd |=> cfg_rvld_q)
		else $error("read not answered");
	chk_idle_reset: assert property ($fell(sys_rst) ##1 cfg_rd
		&& cfg_addr == 8'h0d |=> cfg_rdata_q == 8'hfa) else $error("idle");
	chk_high_zero: assert property (cfg_rvld_q &&
		$past(cfg_addr) == 8'h0e |-> cfg_rdata_q[7:2] == 6'h00) else $error("hi");
	chk_mode_field: assert property (cfg_rvld_q &&
		$past(cfg_addr) == 8'h0f |-> cfg_rdata_q[7:6] == $past(mode_in, 2))
		else $error("mode");
	chk_loop_field: assert property (cfg_rvld_q &&
		$past(cfg_addr) == 8'h0f |-> cfg_rdata_q[5] == loop_en_q) else $error("lp");
	chk_tick_slot: assert property (rx_tick |-> ##[1:2] out_vld_q)
		else $error("no slot output");
endmodule
bind asir_regs asir_regs_props u_asir_regs_props (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .mode_in(mode_in),
	.cfg_rdata_q(cfg_rdata_q), .cfg_rvld_q(cfg_rvld_q), .rx_tick(rx_tick),
	.out_vld_q(out_vld_q), .loop_en_q(loop_en_q));

// file: tb/test_asir_regs.sv
`timescale 1ns/10ps
module test_asir_regs;
	reg        clk_sys = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
	reg        rx_valid = 1'b0, rx_tick = 1'b0, loop_pin = 1'b1;
	reg  [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00;
	reg  [1:0] mode_in = 2'h0;
	reg  [9:0] rx_data = 10'h000;
	wire [7:0] cfg_rdata_q;
	wire [9:0] out_data_q;
	wire       cfg_rvld_q, rx_ready, out_vld_q, loop_en_q, idle_ins_q;
	integer    mismatches = 0, tests_run = 0, n = 0, i;
	// loop strap driven by the bench so both levels are seen
	asir_regs u_asir_regs (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_rdata_q(cfg_rdata_q), .cfg_rvld_q(cfg_rvld_q),
		.loop_pin(loop_pin), .mode_in(mode_in), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_tick(rx_tick), .rx_ready(rx_ready),
		.out_data_q(out_data_q), .out_vld_q(out_vld_q),
		.loop_en_q(loop_en_q), .idle_ins_q(idle_ins_q));
	// 8 ns clock
	initial forever #4 clk_sys = ~clk_sys;
	task ck(input ok);
		tests_run = tests_run + 1;
		mismatches = mismatches + !ok;
		if (!ok) $display("wrong value at %0t: check %0d", $time, tests_run);
	endtask
	// inputs move 1 ns after the edge, clear of sampling
	task acc(input w, input [7:0] a, v, m);
		@(posedge clk_sys) #1 {cfg_addr, cfg_wdata} = {a, v};
		{cfg_wr, cfg_rd} = {w, !w};
		@(posedge clk_sys) #1 {cfg_wr, cfg_rd} = 2'b00;
		if (!w) ck({cfg_rvld_q, cfg_rdata_q & m} === {1'b1, v});
	endtask
	task tick(input [9:0] e, input idle);
		@(posedge clk_sys) #1 rx_tick = 1'b1;
		@(posedge clk_sys) #1 rx_tick = 1'b0;
		ck({out_vld_q, idle_ins_q, out_data_q} === {1'b1, idle, e});
	endtask
	task t_regs;
		acc(1'b0, 8'h0d, 8'hfa, 8'hff);
		tick(10'h0fa, 1'b1);
		acc(1'b1, 8'h0d, 8'h3c, 8'h00);
		acc(1'b1, 8'h0e, 8'hff, 8'h00);
		acc(1'b0, 8'h0e, 8'h03, 8'hff);
		acc(1'b0, 8'h10, 8'h00, 8'hff);
		tick(10'h33c, 1'b1);
		for (i = 0; i < 3; i = i + 1) begin
			mode_in = i[1:0];
			acc(1'b0, 8'h0f, {i[1:0], 6'h20}, 8'he0);
		end
	endtask
	// mid-run reset with the strap low; later pin moves must not matter
	task t_strap;
		@(posedge clk_sys) #1 sys_rst = 1'b1;
		loop_pin = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		acc(1'b0, 8'h0d, 8'hfa, 8'hff);
		acc(1'b0, 8'h0f, 8'h00, 8'h20);
		loop_pin = 1'b1;
		acc(1'b0, 8'h0f, 8'h00, 8'h20);
		tick(10'h0fa, 1'b1);
	endtask
	// 16 words in memory plus one in the output register
	task t_fill;
		rx_valid = 1'b1;
		repeat (24) begin
			n = n + rx_ready;
			@(posedge clk_sys) #1 rx_data = n[9:0];
		end
		ck(rx_ready === 1'b0);
		ck(n === 17);
		rx_valid = 1'b0;
		for (i = 0; i < 17; i = i + 1) tick(i[9:0], 1'b0);
		tick(10'h0fa, 1'b1);
	endtask
	// reset 12 cycles, then scenarios
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		t_regs;
		t_strap;
		t_fill;
		test_done(1'b0);
	end
	// watchdog: run needs ~100 cycles
	initial #20000 test_done(1'b1);
	task test_done(input hung);
		mismatches = mismatches + hung;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
endmodule
